/* File: pkg/ssmr_pkg.sv */
// shared scratch memory with rings: constants, command codes, register map
package ssmr_pkg;

  // storage geometry
  localparam int unsigned MEM_WORDS = 4096;
  localparam int unsigned AW        = 12;
  localparam int unsigned DW        = 32;
  localparam int unsigned LW        = 5;
  localparam int unsigned MAX_LEN   = 16;
  localparam int unsigned NRING     = 16;
  localparam int unsigned RW        = 4;

  // engine command codes
  typedef enum logic [3:0] {
    OP_RD, OP_WR, OP_SET, OP_CLR, OP_INC, OP_DEC, OP_ADD, OP_SUB,
    OP_SWAP, OP_GET, OP_PUT
  } ssmr_op_t;

  // bus word address regions, address[15:12]
  localparam logic [3:0] RGN_MEM  = 4'h0;
  localparam logic [3:0] RGN_SET  = 4'h1;
  localparam logic [3:0] RGN_CLR  = 4'h2;
  localparam logic [3:0] RGN_INC  = 4'h3;
  localparam logic [3:0] RGN_DEC  = 4'h4;
  localparam logic [3:0] RGN_ADD  = 4'h5;
  localparam logic [3:0] RGN_SUB  = 4'h6;
  localparam logic [3:0] RGN_SWAP = 4'h7;
  localparam logic [3:0] RGN_REG  = 4'h8;

  // register offsets inside the register region, address[11:0]
  localparam logic [11:0] REG_IRQ_STAT = 12'h040;
  localparam logic [11:0] REG_IRQ_MASK = 12'h041;
  localparam logic [1:0]  RREG_HEAD    = 2'h0;
  localparam logic [1:0]  RREG_TAIL    = 2'h1;
  localparam logic [1:0]  RREG_SIZE    = 2'h2;
  localparam logic [1:0]  RREG_COUNT   = 2'h3;

  // ring size code 0..3 = 128, 256, 512, 1024 words
  localparam logic [1:0]    SIZE_RST  = 2'h0;
  localparam logic [AW-1:0] SIZE_UNIT = 12'h080;
  localparam logic [AW-1:0] PTR_RST   = 12'h000;
  localparam int unsigned   NF_MARGIN = 16;

  // interrupt event bits
  localparam int unsigned NEV       = 3;
  localparam int unsigned EV_UNDER  = 0;
  localparam int unsigned EV_OVER   = 1;
  localparam int unsigned EV_BADLEN = 2;
  localparam logic [NEV-1:0] IRQ_RST = 3'h0;

endpackage : ssmr_pkg

/* File: core/ssmr_ring.sv */
// one hardware ring: head, tail, size, derived count and near-full flag
module ssmr_ring #(
  parameter int unsigned NF_MARGIN = ssmr_pkg::NF_MARGIN
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // configuration writes
  input  wire logic                       cfg_we,
  input  wire logic [1:0]                 cfg_sel,
  input  wire logic [ssmr_pkg::AW-1:0]    cfg_data,
  // pointer advance after a get or put
  input  wire logic                       adv_head,
  input  wire logic                       adv_tail,
  input  wire logic [ssmr_pkg::LW-1:0]    adv_len,
  // ring state
  output logic      [ssmr_pkg::AW-1:0]    head,
  output logic      [ssmr_pkg::AW-1:0]    tail,
  output logic      [ssmr_pkg::AW-1:0]    mask,
  output logic      [ssmr_pkg::AW-1:0]    count,
  output logic      [1:0]                 size_code,
  output logic                            near_full
);
  import ssmr_pkg::*;

  localparam logic [AW:0] NF_W = (AW+1)'(NF_MARGIN);

  logic [AW-1:0] head_q, head_d, tail_q, tail_d, step;
  logic [1:0]    size_q, size_d;
  logic          nf_q, nf_d;

  // size code picks the region mask; region is aligned to its size
  assign mask      = (SIZE_UNIT << size_q) - 12'h001; // R10 R11
  assign count     = (tail_q - head_q) & mask;        // R08
  assign head      = head_q;
  assign tail      = tail_q;
  assign size_code = size_q;
  assign near_full = nf_q;
  assign step      = {{(AW-LW){1'b0}}, adv_len};

  // next state: pointers stay inside the aligned region
  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    size_d = size_q;
    if (cfg_we && cfg_sel == RREG_HEAD) begin
      head_d = cfg_data;
    end else if (adv_head) begin
      head_d = (head_q & ~mask) | ((head_q + step) & mask); // R19 R09
    end
    if (cfg_we && cfg_sel == RREG_TAIL) begin
      tail_d = cfg_data;
    end else if (adv_tail) begin
      tail_d = (tail_q & ~mask) | ((tail_q + step) & mask); // R19 R09
    end
    if (cfg_we && cfg_sel == RREG_SIZE) begin
      size_d = cfg_data[1:0]; // R10
    end
    // registered, so it trails the put by a cycle
    nf_d = ({1'b0, count} + NF_W) > {1'b0, mask}; // R14
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      head_q <= PTR_RST;
      tail_q <= PTR_RST;
      size_q <= SIZE_RST;
      nf_q   <= 1'b0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      size_q <= size_d;
      nf_q   <= nf_d;
    end
  end

  a_head_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n) // R19
    adv_head && !cfg_we |=> (head_q & ~mask) == $past(head_q & ~mask))
    else $error("head left its ring region");

  a_near_full: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    ({1'b0, count} + NF_W > {1'b0, mask}) |=> near_full)
    else $error("near-full not raised");

endmodule : ssmr_ring

/* File: core/ssmr_top.sv */
// scratch memory unit: 4K words, atomics, sixteen rings, bus slave
//
// Contract
// R01: 16 KB as 4K 32-bit shared words
// R02: normal read/write moves one to sixteen words
// R03: no byte masking, whole words only
// R04: seven atomic ops on one word, indivisible
// R05: atomic optionally returns the old value
// R06: engine command or bus alias window selects op
// R07: sixteen rings, get/put with ring and length
// R08: head, tail, size kept; count from pointers
// R09: get reads at head, put writes at tail
// R10: ring size 128, 256, 512 or 1024
// R11: software aligns ring region to its size
// R12: ring regions get no access protection
// R13: software keeps ring regions apart
// R14: per-ring near-full output, may lag puts
// R15: producer tests flag, waits for pull signal
// R16: producer limits put length, sixteen maximum
// R17: flag scheme illegal when one word overfills
// R18: space may be reserved by atomic sub/add
// R19: pointers wrap modulo size within region
module ssmr_top #(
  parameter int unsigned NF_MARGIN = ssmr_pkg::NF_MARGIN
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // avalon-mm slave, word addressed
  input  wire logic [15:0]                   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [ssmr_pkg::DW-1:0]       avs_writedata,
  output logic      [ssmr_pkg::DW-1:0]       avs_readdata,
  output logic                               avs_waitrequest,
  // engine command
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire ssmr_pkg::ssmr_op_t            cmd_op,
  input  wire logic [ssmr_pkg::AW-1:0]       cmd_addr,
  input  wire logic [ssmr_pkg::RW-1:0]       cmd_ring,
  input  wire logic [ssmr_pkg::LW-1:0]       cmd_len,
  input  wire logic                          cmd_ret,
  input  wire logic [ssmr_pkg::DW-1:0]       cmd_opnd,
  // engine write data
  input  wire logic                          wd_valid,
  input  wire logic [ssmr_pkg::DW-1:0]       wd_data,
  output logic                               wd_ready,
  // engine read data and completion
  output logic                               rd_valid,
  output logic      [ssmr_pkg::DW-1:0]       rd_data,
  output logic                               rd_last,
  output logic                               cmd_done,
  // ring flags and interrupt
  output logic      [ssmr_pkg::NRING-1:0]    near_full,
  output logic                               irq
);
  import ssmr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} ssmr_st_t;

  // storage, no reset: contents are software's business
  logic [DW-1:0] mem_q [MEM_WORDS]; // R01
  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [DW-1:0] mem_wd;

  // ring wires
  logic [AW-1:0]    r_head [NRING];
  logic [AW-1:0]    r_tail [NRING];
  logic [AW-1:0]    r_mask [NRING];
  logic [AW-1:0]    r_count [NRING];
  logic [1:0]       r_size [NRING];
  logic [NRING-1:0] cfg_we, adv_head, adv_tail;

  // control state
  ssmr_st_t       st_q, st_d;
  logic [AW-1:0]  base_q, base_d, off_q, off_d, xmask_q, xmask_d;
  logic [LW-1:0]  left_q, left_d, len_q, len_d;
  logic [RW-1:0]  ring_q, ring_d;
  logic           isring_q, isring_d;
  logic           ack_q, ack_d;
  logic [DW-1:0]  rdata_q, rdata_d;
  logic           rd_valid_q, rd_valid_d, rd_last_q, rd_last_d;
  logic [DW-1:0]  rd_data_q, rd_data_d;
  logic           done_q, done_d;
  logic [NEV-1:0] stat_q, stat_d, imask_q, imask_d, ev, stat_clr;

  // decode helpers
  logic          avs_req, av_go, cmd_go, len_bad;
  logic [3:0]    rgn;
  logic [AW-1:0] aoff, cur_addr, xlen;
  logic [RW-1:0] rsel;
  logic [DW-1:0] av_old, cmd_old, cur_rd;
  ssmr_op_t      aop;

  // one word modify step shared by engine and bus paths
  function automatic logic [DW-1:0] atom(ssmr_op_t op, logic [DW-1:0] v,
                                         logic [DW-1:0] o);
    case (op)
      OP_SET:  atom = v | o;
      OP_CLR:  atom = v & ~o;
      OP_INC:  atom = v + 32'h0000_0001;
      OP_DEC:  atom = v - 32'h0000_0001;
      OP_ADD:  atom = v + o;
      OP_SUB:  atom = v - o;
      OP_SWAP: atom = o;
      default: atom = v;
    endcase
  endfunction : atom

  // alias window number to operation
  function automatic ssmr_op_t alias_op(logic [3:0] r);
    case (r)
      RGN_SET:  alias_op = OP_SET;
      RGN_CLR:  alias_op = OP_CLR;
      RGN_INC:  alias_op = OP_INC;
      RGN_DEC:  alias_op = OP_DEC;
      RGN_ADD:  alias_op = OP_ADD;
      RGN_SUB:  alias_op = OP_SUB;
      RGN_SWAP: alias_op = OP_SWAP;
      default:  alias_op = OP_RD;
    endcase
  endfunction : alias_op

  function automatic logic is_atom(ssmr_op_t op);
    is_atom = (op inside {OP_SET, OP_CLR, OP_INC, OP_DEC, OP_ADD, OP_SUB,
                          OP_SWAP});
  endfunction : is_atom

  // sixteen ring register sets
  for (genvar g = 0; g < NRING; g++) begin : g_ring
    ssmr_ring #(
      .NF_MARGIN (NF_MARGIN)
    ) u_ring (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .cfg_we    (cfg_we[g]),
      .cfg_sel   (aoff[1:0]),
      .cfg_data  (avs_writedata[AW-1:0]),
      .adv_head  (adv_head[g]),
      .adv_tail  (adv_tail[g]),
      .adv_len   (len_q),
      .head      (r_head[g]),
      .tail      (r_tail[g]),
      .mask      (r_mask[g]),
      .count     (r_count[g]),
      .size_code (r_size[g]),
      .near_full (near_full[g])
    );
  end

  // bus is served only from idle, so a burst delays it
  assign avs_req         = avs_read | avs_write;
  assign av_go           = avs_req & ~ack_q & (st_q == ST_IDLE);
  assign cmd_ready       = (st_q == ST_IDLE) & ~(avs_req & ~ack_q);
  assign cmd_go          = cmd_valid & cmd_ready;
  assign avs_waitrequest = avs_req & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign rgn             = avs_address[15:12];
  assign aoff            = avs_address[11:0];
  assign rsel            = aoff[5:2];
  assign aop             = alias_op(rgn);
  assign xlen            = {{(AW-LW){1'b0}}, cmd_len};
  assign len_bad         = (cmd_len == 5'h00) || (cmd_len > 5'h10); // R02
  assign cur_addr        = base_q | (off_q & xmask_q);
  assign av_old          = mem_q[aoff];
  assign cmd_old         = mem_q[cmd_addr];
  assign cur_rd          = mem_q[cur_addr];
  assign wd_ready        = (st_q == ST_WR);
  assign rd_valid        = rd_valid_q;
  assign rd_data         = rd_data_q;
  assign rd_last         = rd_last_q;
  assign cmd_done        = done_q;
  assign irq             = |(stat_q & imask_q);

  // next state for command engine, bus slave and event flags
  always_comb begin
    st_d       = st_q;
    base_d     = base_q;
    off_d      = off_q;
    xmask_d    = xmask_q;
    left_d     = left_q;
    len_d      = len_q;
    ring_d     = ring_q;
    isring_d   = isring_q;
    ack_d      = 1'b0;
    rdata_d    = rdata_q;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    rd_last_d  = 1'b0;
    done_d     = 1'b0;
    ev         = '0;
    stat_clr   = '0;
    imask_d    = imask_q;
    mem_we     = 1'b0;
    mem_wa     = cur_addr;
    mem_wd     = wd_data;
    cfg_we     = '0;
    adv_head   = '0;
    adv_tail   = '0;
    case (st_q)
      ST_IDLE: begin
        if (av_go) begin
          ack_d   = 1'b1;
          rdata_d = '0;
          if (rgn == RGN_MEM) begin
            // plain window: ring regions are not guarded
            rdata_d = av_old; // R12
            if (avs_write) begin
              mem_we = 1'b1;
              mem_wa = aoff;
              mem_wd = avs_writedata; // R03
            end
          end else if (rgn <= RGN_SWAP) begin
            // alias window: write applies op, inc/dec also on read
            rdata_d = av_old; // R05
            if (avs_write || aop == OP_INC || aop == OP_DEC) begin
              mem_we = 1'b1; // R06 R04
              mem_wa = aoff;
              mem_wd = atom(aop, av_old, avs_writedata);
            end
          end else if (rgn == RGN_REG && aoff[11:6] == 6'h00) begin
            case (aoff[1:0])
              RREG_HEAD:  rdata_d = {{(DW-AW){1'b0}}, r_head[rsel]};
              RREG_TAIL:  rdata_d = {{(DW-AW){1'b0}}, r_tail[rsel]};
              RREG_SIZE:  rdata_d = {30'h0, r_size[rsel]};
              default:    rdata_d = {{(DW-AW){1'b0}}, r_count[rsel]};
            endcase
            // count is derived and read only
            cfg_we[rsel] = avs_write && (aoff[1:0] != RREG_COUNT); // R08
          end else if (rgn == RGN_REG && aoff == REG_IRQ_STAT) begin
            rdata_d  = {{(DW-NEV){1'b0}}, stat_q};
            stat_clr = avs_write ? avs_writedata[NEV-1:0] : '0;
          end else if (rgn == RGN_REG && aoff == REG_IRQ_MASK) begin
            rdata_d = {{(DW-NEV){1'b0}}, imask_q};
            if (avs_write) begin
              imask_d = avs_writedata[NEV-1:0];
            end
          end
        end else if (cmd_go) begin
          len_d    = cmd_len;
          left_d   = cmd_len;
          ring_d   = cmd_ring;
          isring_d = 1'b0;
          base_d   = '0;
          off_d    = cmd_addr;
          xmask_d  = '1;
          if (is_atom(cmd_op)) begin
            // single cycle modify, nothing else can interleave
            mem_we = 1'b1; // R04 R06
            mem_wa = cmd_addr;
            mem_wd = atom(cmd_op, cmd_old, cmd_opnd);
            rd_valid_d = cmd_ret; // R05
            rd_last_d  = cmd_ret;
            rd_data_d  = cmd_old;
            done_d     = 1'b1;
          end else if (len_bad) begin
            ev[EV_BADLEN] = 1'b1; // R02
            done_d        = 1'b1;
          end else begin
            case (cmd_op)
              OP_RD: st_d = ST_RD;
              OP_WR: st_d = ST_WR;
              OP_GET: begin
                // refuse a get that asks for more than is queued
                isring_d = 1'b1; // R07
                xmask_d  = r_mask[cmd_ring];
                base_d   = r_head[cmd_ring] & ~r_mask[cmd_ring];
                off_d    = r_head[cmd_ring]; // R09
                if (r_count[cmd_ring] < xlen) begin
                  ev[EV_UNDER] = 1'b1;
                  done_d       = 1'b1;
                end else begin
                  st_d = ST_RD;
                end
              end
              OP_PUT: begin
                // overfill is flagged but still written
                isring_d = 1'b1; // R07
                xmask_d  = r_mask[cmd_ring];
                base_d   = r_tail[cmd_ring] & ~r_mask[cmd_ring];
                off_d    = r_tail[cmd_ring]; // R09
                ev[EV_OVER] = (r_count[cmd_ring] + xlen) > r_mask[cmd_ring];
                st_d = ST_WR;
              end
              default: begin
                ev[EV_BADLEN] = 1'b1;
                done_d        = 1'b1;
              end
            endcase
          end
        end
      end
      ST_RD: begin
        // one word a cycle, wrapping inside a ring region
        rd_valid_d = 1'b1;
        rd_data_d  = cur_rd;
        off_d      = off_q + 12'h001; // R19
        left_d     = left_q - 5'h01;
        if (left_q == 5'h01) begin
          rd_last_d = 1'b1;
          done_d    = 1'b1;
          st_d      = ST_IDLE;
          adv_head[ring_q] = isring_q; // R09
        end
      end
      ST_WR: begin
        // whole words only; the source may stall with wd_valid low
        if (wd_valid) begin
          mem_we = 1'b1; // R03
          off_d  = off_q + 12'h001; // R19
          left_d = left_q - 5'h01;
          if (left_q == 5'h01) begin
            // done tells the producer its data was pulled
            done_d = 1'b1; // R15
            st_d   = ST_IDLE;
            adv_tail[ring_q] = isring_q; // R09
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // a new event wins over a clear in the same cycle
    stat_d = (stat_q & ~stat_clr) | ev;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      base_q     <= '0;
      off_q      <= '0;
      xmask_q    <= '0;
      left_q     <= '0;
      len_q      <= '0;
      ring_q     <= '0;
      isring_q   <= 1'b0;
      ack_q      <= 1'b0;
      rdata_q    <= '0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
      rd_last_q  <= 1'b0;
      done_q     <= 1'b0;
      stat_q     <= IRQ_RST;
      imask_q    <= IRQ_RST;
    end else begin
      st_q       <= st_d;
      base_q     <= base_d;
      off_q      <= off_d;
      xmask_q    <= xmask_d;
      left_q     <= left_d;
      len_q      <= len_d;
      ring_q     <= ring_d;
      isring_q   <= isring_d;
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
      rd_last_q  <= rd_last_d;
      done_q     <= done_d;
      stat_q     <= stat_d;
      imask_q    <= imask_d;
    end
  end

  // storage write port
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    av_go |=> !avs_waitrequest && ack_q)
    else $error("bus access not answered after one wait cycle");

  a_xfer_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // R02
    st_q != ST_IDLE |-> left_q >= 5'h01 && left_q <= 5'h10)
    else $error("transfer length outside one to sixteen");

  a_inc_store: assert property (@(posedge clk_sys) disable iff (!rst_n) // R04
    cmd_go && cmd_op == OP_INC
    |=> mem_q[$past(cmd_addr)] == $past(cmd_old) + 32'h0000_0001)
    else $error("increment did not store old plus one");

  a_old_return: assert property (@(posedge clk_sys) disable iff (!rst_n) // R05
    cmd_go && is_atom(cmd_op) && cmd_ret
    |=> rd_valid && rd_last && cmd_done && rd_data == $past(cmd_old))
    else $error("atomic did not return the old value");

  a_word_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // R03
    wd_ready && wd_valid |=> mem_q[$past(cur_addr)] == $past(wd_data))
    else $error("write word not stored whole");

  a_get_head: assert property (@(posedge clk_sys) disable iff (!rst_n) // R09
    cmd_go && cmd_op == OP_GET && !len_bad && r_count[cmd_ring] >= xlen
    |=> st_q == ST_RD && cur_addr == $past(r_head[cmd_ring]))
    else $error("get did not start at head");

  a_put_tail: assert property (@(posedge clk_sys) disable iff (!rst_n) // R09
    cmd_go && cmd_op == OP_PUT && !len_bad
    |=> st_q == ST_WR && cur_addr == $past(r_tail[cmd_ring]))
    else $error("put did not start at tail");

  a_rd_burst: assert property (@(posedge clk_sys) disable iff (!rst_n) // R02
    cmd_go && cmd_op == OP_RD && cmd_len == 5'h02 && !len_bad
    |=> ##1 rd_valid && !rd_last ##1 rd_valid && rd_last && cmd_done)
    else $error("two word read not delivered in two beats");

endmodule : ssmr_top

/* File: tb/ssmr_engine_model.sv */
// engine-side partner: issues one command, pushes and gathers words
module ssmr_engine_model (
  // clock
  input  wire logic                    clk_sys,
  // command
  output logic                         cmd_valid,
  input  wire logic                    cmd_ready,
  output ssmr_pkg::ssmr_op_t           cmd_op,
  output logic [ssmr_pkg::AW-1:0]      cmd_addr,
  output logic [ssmr_pkg::RW-1:0]      cmd_ring,
  output logic [ssmr_pkg::LW-1:0]      cmd_len,
  output logic                         cmd_ret,
  output logic [ssmr_pkg::DW-1:0]      cmd_opnd,
  // words both ways
  output logic                         wd_valid,
  output logic [ssmr_pkg::DW-1:0]      wd_data,
  input  wire logic                    wd_ready,
  input  wire logic                    rd_valid,
  input  wire logic [ssmr_pkg::DW-1:0] rd_data,
  input  wire logic                    rd_last,
  input  wire logic                    cmd_done
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssmr_pkg::*;
  logic [DW-1:0] wq [16];
  logic [DW-1:0] rq [16];
  int            nrd;
  int            lastat;
  int            hangs = 0;

  // idle levels at time zero
  initial begin
    {cmd_valid, cmd_ret, wd_valid} = 3'h0;
    {cmd_addr, cmd_ring, cmd_len, cmd_opnd, wd_data} = '0;
    cmd_op = OP_RD;
  end

  // one command, whole 32-bit words only; next only after done
  task automatic run(input ssmr_op_t op, input logic [11:0] a,
                     input logic [3:0] r, input logic [4:0] n,
                     input logic rt, input logic [31:0] od);
    int i;
    int t;
    i = 0;
    t = 0;
    nrd = 0;
    lastat = 0;
    @(posedge clk_sys);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_ring <= r;
    cmd_len <= n;
    cmd_ret <= rt;
    cmd_opnd <= od;
    cmd_valid <= 1'b1;
    wd_valid <= (op == OP_WR || op == OP_PUT) && n != 0;
    wd_data <= wq[0];
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++t < 200);
    cmd_valid <= 1'b0;
    while (cmd_done !== 1'b1 && ++t < 400) begin
      @(posedge clk_sys);
      if (rd_valid === 1'b1 && nrd < 16) begin
        rq[nrd] = rd_data;
        nrd++;
        if (rd_last === 1'b1) begin
          lastat = nrd;
        end
      end
      if (wd_valid && wd_ready === 1'b1) begin
        i++;
        wd_valid <= (i < n);
        // released data line shows no stale word
        wd_data <= (i < n) ? wq[i[3:0]] : ~wd_data;
      end
    end
    wd_valid <= 1'b0;
    // a command that never finished is a hang, not a silent pass
    if (cmd_done !== 1'b1) begin
      hangs++;
    end
  endtask : run
endmodule : ssmr_engine_model

/* File: tb/tb_top.sv */
// top-level bench for the scratch memory unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssmr_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst_n = 1'b0;
  logic [15:0]      avs_address = 16'h0000;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [DW-1:0]    avs_writedata = 32'h0;
  logic [DW-1:0]    avs_readdata, rd_data, wd_data, cmd_opnd, q, v;
  logic             avs_waitrequest, cmd_valid, cmd_ready, cmd_ret, irq;
  logic             wd_valid, wd_ready, rd_valid, rd_last, cmd_done;
  ssmr_op_t         cmd_op;
  logic [AW-1:0]    cmd_addr;
  logic [RW-1:0]    cmd_ring;
  logic [LW-1:0]    cmd_len;
  logic [NRING-1:0] near_full;
  int               fail_count = 0;
  int               comparisons = 0;

  always #5 clk_sys = ~clk_sys;

  ssmr_top DUT (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_addr, .cmd_ring, .cmd_len, .cmd_ret, .cmd_opnd, .wd_valid,
    .wd_data, .wd_ready, .rd_valid, .rd_data, .rd_last, .cmd_done,
    .near_full, .irq);
  ssmr_engine_model eng (.clk_sys, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_ring, .cmd_len, .cmd_ret, .cmd_opnd, .wd_valid,
    .wd_data, .wd_ready, .rd_valid, .rd_data, .rd_last, .cmd_done);

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0 && ++t < 100);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic t_mem();
    bus(1'b1, 16'h0fff, 32'ha5c3_0ff1);
    bus(1'b0, 16'h0fff, 32'h0);
    chk("mem_top", q, 32'ha5c3_0ff1);
    for (int i = 0; i < 16; i++) eng.wq[i] = 32'h1234_0000 + i;
    eng.run(OP_WR, 12'h200, 4'h0, 5'h10, 1'b0, 32'h0);
    eng.run(OP_RD, 12'h200, 4'h0, 5'h10, 1'b0, 32'h0);
    chk("rd_count", eng.nrd, 16);
    for (int i = 0; i < 16; i++) begin
      chk("rd_word", eng.rq[i], 32'h1234_0000 + i);
    end
    chk("rd_last", eng.lastat, 16);
    eng.run(OP_RD, 12'h200, 4'h0, 5'h02, 1'b0, 32'h0);
    chk("rd_two", eng.rq[1], 32'h1234_0001);
    chk("rd_two_last", eng.lastat, 2);
    bus(1'b0, 16'h020f, 32'h0);
    chk("shared", q, 32'h1234_000f);
  endtask : t_mem

  task automatic t_atom();
    ssmr_op_t op;
    v = 32'h0000_f0f0;
    bus(1'b1, 16'h0300, v);
    for (int j = 2; j <= 8; j++) begin
      op = ssmr_op_t'(j);
      eng.run(op, 12'h300, 4'h0, 5'h01, 1'b1, 32'h0000_0f0c);
      chk("old_value", eng.rq[0], v);
      case (op)
        OP_SET: v = v | 32'h0f0c;
        OP_CLR: v = v & ~32'h0f0c;
        OP_INC: v = v + 1;
        OP_DEC: v = v - 1;
        OP_ADD: v = v + 32'h0f0c;
        OP_SUB: v = v - 32'h0f0c;
        default: v = 32'h0f0c;
      endcase
      bus(1'b0, 16'h0300, 32'h0);
      chk("rmw_word", q, v);
    end
    // space counter reserved by subtract, released by add
    bus(1'b1, 16'h0301, 32'd8);
    bus(1'b1, 16'h6301, 32'd3);
    bus(1'b0, 16'h5301, 32'h0);
    chk("alias_sub", q, 32'd5);
    eng.run(OP_INC, 12'h301, 4'h0, 5'h01, 1'b0, 32'h0);
    chk("no_return", eng.nrd, 0);
    bus(1'b1, 16'h5301, 32'd1);
    bus(1'b0, 16'h0301, 32'h0);
    chk("alias_add", q, 32'd7);
  endtask : t_atom

  task automatic t_ring();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 16'h800e, c);
      bus(1'b0, 16'h800e, 32'h0);
      chk("size_code", q, c);
    end
    // region 0x100..0x17f, aligned to 128, no other ring in it
    bus(1'b1, 16'h800e, 32'h0);
    bus(1'b1, 16'h800c, 32'h17e);
    bus(1'b1, 16'h800d, 32'h17e);
    for (int i = 0; i < 4; i++) eng.wq[i] = 32'hc0de_0000 + i;
    eng.run(OP_PUT, 12'h0, 4'h3, 5'h04, 1'b0, 32'h0);
    bus(1'b0, 16'h800d, 32'h0);
    chk("tail_wrap", q, 32'h102);
    bus(1'b0, 16'h800f, 32'h0);
    chk("count", q, 32'd4);
    bus(1'b0, 16'h0100, 32'h0);
    chk("wrap_word", q, 32'hc0de_0002);
    bus(1'b1, 16'h0101, 32'hbeef_0001);
    eng.run(OP_GET, 12'h0, 4'h3, 5'h04, 1'b0, 32'h0);
    chk("get_first", eng.rq[0], 32'hc0de_0000);
    chk("get_plain", eng.rq[3], 32'hbeef_0001);
    bus(1'b0, 16'h800c, 32'h0);
    chk("head_wrap", q, 32'h102);
    for (int k = 0; k < 7; k++) begin
      chk("near_full", near_full, 16'h0000);
      eng.run(OP_PUT, 12'h0, 4'h3, 5'h10, 1'b0, 32'h0);
    end
    repeat (3) @(negedge clk_sys);
    chk("near_full", near_full, 16'h0008);
  endtask : t_ring

  task automatic t_irq();
    chk("irq_idle", irq, 1'b0);
    bus(1'b1, 16'h8041, 32'h7);
    eng.run(OP_PUT, 12'h0, 4'h3, 5'h10, 1'b0, 32'h0);
    eng.run(OP_GET, 12'h0, 4'h5, 5'h01, 1'b0, 32'h0);
    chk("get_empty", eng.nrd, 0);
    eng.run(OP_RD, 12'h0, 4'h0, 5'h00, 1'b0, 32'h0);
    bus(1'b0, 16'h8040, 32'h0);
    chk("irq_stat", q, 32'h7);
    chk("irq_on", irq, 1'b1);
    bus(1'b1, 16'h8040, 32'h2);
    bus(1'b0, 16'h8040, 32'h0);
    chk("irq_w1c", q, 32'h5);
    bus(1'b1, 16'h8041, 32'h0);
    @(negedge clk_sys);
    chk("irq_mask", irq, 1'b0);
    bus(1'b0, 16'h9000, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask : t_irq

  task automatic close_out();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_mem();
    t_atom();
    t_ring();
    t_irq();
    chk("eng_hang", eng.hangs, 0);
    close_out();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end
endmodule : tb_top
